// ===== tls_seq_regs.vh
// Purpose: constants for the mode sequencer
// Assumes: 50 MHz system clock
// Notes: register offsets are index values, byte address is index times four
`ifndef TLS_SEQ_REGS_VH
`define TLS_SEQ_REGS_VH
`define TLS_REG_CTRL 4'h0
`define TLS_REG_CFG 4'h1
`define TLS_REG_TMR 4'h2
`define TLS_REG_STAT 4'h3
`define TLS_CTRL_LAUNCH 0
`define TLS_CTRL_STOP 1
`define TLS_CFG_IDLE_PWR 0
`define TLS_CFG_START_LSB 1
`define TLS_CFG_LOWPWR 3
`define TLS_CFG_IDLE_EXIT 4
`define TLS_CFG_TX_EXIT 5
`define TLS_CFG_RX_LSB 6
`define TLS_CFG_TO_LSB 9
`define TLS_CFG_PKT_LSB 11
`define TLS_CFG_CRC_ON 14
`define TLS_CFG_AUTOFLUSH 15
`define TLS_CFG_RESET 16'h0000
`define TLS_TMR_RESET 20'h00000
`define TLS_CLK_MHZ 50
`define TLS_STEP_US 64
`define TLS_STEP_CYC (`TLS_STEP_US * `TLS_CLK_MHZ)
`define TLS_MODE_SLEEP 3'h0
`define TLS_MODE_STDBY 3'h1
`define TLS_MODE_SYNTH 3'h2
`define TLS_MODE_TX 3'h3
`define TLS_MODE_RX 3'h5
`endif

// ===== tls_timer.v
// Purpose: one sequencer interval timer
// Assumes: tick is a one-cycle 64 us enable pulse
// Notes: step code 00 disables, 01 1 tick, 10 64 ticks, 11 4096 ticks
`timescale 1ns/1ps
module tls_timer
#(
    parameter MW = 8
)
(
    input wire clk,
    input wire srst,
    input wire tick,
    input wire start,
    input wire [1:0] step,
    input wire [MW-1:0] mult,
    output reg expire
);
    reg [11:0] sub_q;
    reg [MW-1:0] cnt_q;
    reg run_q;
    wire [11:0] sub_max;

    // step length in ticks: 64 us, 4.1 ms, 262 ms
    assign sub_max = (step == 2'h1) ? 12'h000 :
                     (step == 2'h2) ? 12'h03f : 12'hfff;

    always @(posedge clk)
    begin
        if (srst)
        begin
            sub_q <= 12'h000;
            cnt_q <= {MW{1'b0}};
            run_q <= 1'b0;
            expire <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (start)
            begin
                // disabled timer or zero multiplier never fires
                run_q <= (step != 2'h0) && (mult != {MW{1'b0}});
                sub_q <= 12'h000;
                cnt_q <= {MW{1'b0}};
            end
            else if (run_q && tick)
            begin
                if (sub_q == sub_max)
                begin
                    sub_q <= 12'h000;
                    if (cnt_q == mult - 1'b1)
                    begin
                        run_q <= 1'b0;
                        expire <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                else
                    sub_q <= sub_q + 1'b1;
            end
        end
    end
endmodule // tls_timer

// ===== tls_seq.v
// Purpose: top level mode sequencer for the transceiver
// Assumes: radio events are one-cycle pulses on REF_CLK
// Notes: registers at index 0..3, byte address index times four
`timescale 1ns/1ps
`include "tls_seq_regs.vh"
module tls_seq
#(
    parameter MW = 8
)
(
    input wire REF_CLK,
    input wire SRST,
    input wire [5:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    input wire TX_COMPLETE_IRQ,
    input wire RX_PAYLOAD_AVAIL_IRQ,
    input wire CRC_GOOD_IRQ,
    input wire LEVEL_IRQ,
    input wire SYNC_MATCH_IRQ,
    input wire PREAMBLE_FOUND_IRQ,
    input wire LEVEL_WAIT_TIMEOUT,
    input wire PREAMBLE_WAIT_TIMEOUT,
    input wire SYNC_WAIT_TIMEOUT,
    input wire FIFO_LEVEL_IRQ,
    input wire FIFO_DRAINED_IRQ,
    input wire FREQ_CHANGED,
    output reg [2:0] CHIP_MODE,
    output reg RECEIVER_RELAUNCH,
    output reg [2:0] SEQ_STATE
);
    localparam ST_OFF = 3'h0;
    localparam ST_IDLE = 3'h1;
    localparam ST_TX = 3'h2;
    localparam ST_RX = 3'h3;
    localparam ST_PKT = 3'h4;
    localparam ST_LOWPWR = 3'h5;
    localparam ST_TXWAIT = 3'h6;
    localparam ST_SYNTH = 3'h7;
    localparam STEP_CYC = `TLS_STEP_CYC;

    reg [15:0] cfg_q;
    reg [19:0] tmr_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg init_sleep_q;
    reg [11:0] pre_q;
    reg tick_q;
    reg relaunch_d;
    reg [2:0] mode_d;

    wire [3:0] widx;
    wire is_ctrl_wr;
    wire launch;
    wire stop;
    wire idle_pwr;
    wire [1:0] start_sel;
    wire low_power_choice;
    wire idle_exit;
    wire tx_exit;
    wire [2:0] rx_sel;
    wire [1:0] to_sel;
    wire [2:0] pkt_sel;
    wire crc_on;
    wire autoflush;
    wire first_timer_event;
    wire second_timer_event;
    wire receive_timeout_event;
    wire bad_crc_payload;
    wire [MW-1:0] mult_a;
    wire [MW-1:0] mult_b;

    assign widx = ADDR[5:2];
    assign is_ctrl_wr = WR && (widx == `TLS_REG_CTRL);
    assign launch = is_ctrl_wr && WDATA[`TLS_CTRL_LAUNCH];
    assign stop = is_ctrl_wr && WDATA[`TLS_CTRL_STOP];
    assign idle_pwr = cfg_q[`TLS_CFG_IDLE_PWR];
    assign start_sel = cfg_q[`TLS_CFG_START_LSB +: 2];
    assign low_power_choice = cfg_q[`TLS_CFG_LOWPWR];
    assign idle_exit = cfg_q[`TLS_CFG_IDLE_EXIT];
    assign tx_exit = cfg_q[`TLS_CFG_TX_EXIT];
    assign rx_sel = cfg_q[`TLS_CFG_RX_LSB +: 3];
    assign to_sel = cfg_q[`TLS_CFG_TO_LSB +: 2];
    assign pkt_sel = cfg_q[`TLS_CFG_PKT_LSB +: 3];
    assign crc_on = cfg_q[`TLS_CFG_CRC_ON];
    assign autoflush = cfg_q[`TLS_CFG_AUTOFLUSH];
    assign mult_a = tmr_q[2 +: MW];
    assign mult_b = tmr_q[12 +: MW];

    // payload ready with no crc good, crc checked, no auto flush
    assign bad_crc_payload = (rx_sel == 3'h3) && RX_PAYLOAD_AVAIL_IRQ &&
        !CRC_GOOD_IRQ && crc_on && !autoflush;
    assign receive_timeout_event = LEVEL_WAIT_TIMEOUT ||
        PREAMBLE_WAIT_TIMEOUT || SYNC_WAIT_TIMEOUT ||
        bad_crc_payload;

    // shared 64 us tick for both timers
    always @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            pre_q <= 12'h000;
            tick_q <= 1'b0;
        end
        else if (pre_q == STEP_CYC - 1)
        begin
            pre_q <= 12'h000;
            tick_q <= 1'b1;
        end
        else
        begin
            pre_q <= pre_q + 12'h001;
            tick_q <= 1'b0;
        end
    end

    // first timer restarts on launch or second event; runs in any state
    tls_timer #(.MW(MW)) u_timer_a
    (
        .clk(REF_CLK),
        .srst(SRST || stop),
        .tick(tick_q),
        .start(launch || second_timer_event),
        .step(tmr_q[1:0]),
        .mult(mult_a),
        .expire(first_timer_event)
    );

    tls_timer #(.MW(MW)) u_timer_b
    (
        .clk(REF_CLK),
        .srst(SRST || stop || launch),
        .tick(tick_q),
        .start(first_timer_event),
        .step(tmr_q[11:10]),
        .mult(mult_b),
        .expire(second_timer_event)
    );

    // register file
    always @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            cfg_q <= `TLS_CFG_RESET;
            tmr_q <= `TLS_TMR_RESET;
            RDATA <= 32'h00000000;
        end
        else
        begin
            if (WR && widx == `TLS_REG_CFG)
                cfg_q <= WDATA[15:0];
            if (WR && widx == `TLS_REG_TMR)
                tmr_q <= WDATA[19:0];
            RDATA <= 32'h00000000;
            if (RD)
            begin
                case (widx)
                    `TLS_REG_CFG: RDATA <= {16'h0000, cfg_q};
                    `TLS_REG_TMR: RDATA <= {12'h000, tmr_q};
                    `TLS_REG_STAT: RDATA <= {25'h0000000, init_sleep_q,
                        CHIP_MODE, state_q};
                    default: RDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // next state, one transition per cycle
    always @*
    begin
        state_d = state_q;
        relaunch_d = 1'b0;
        case (state_q)
            ST_OFF:
                if (launch)
                begin
                    case (start_sel)
                        2'h0: state_d = ST_LOWPWR;
                        2'h1: state_d = ST_RX;
                        2'h2: state_d = ST_TX;
                        default: state_d = ST_TXWAIT;
                    endcase
                end
            ST_TXWAIT:
                if (FIFO_LEVEL_IRQ)
                    state_d = ST_TX;
            ST_IDLE:
                if (first_timer_event)
                    state_d = idle_exit ? ST_RX : ST_TX;
            ST_TX:
                if (TX_COMPLETE_IRQ)
                    state_d = tx_exit ? ST_RX : ST_LOWPWR;
            ST_RX:
                if (second_timer_event)
                    state_d = ST_LOWPWR;
                else if (receive_timeout_event)
                begin
                    case (to_sel)
                        2'h0:
                        begin
                            state_d = ST_RX;
                            relaunch_d = 1'b1;
                        end
                        2'h1: state_d = ST_TX;
                        2'h2: state_d = ST_LOWPWR;
                        default: state_d = ST_OFF;
                    endcase
                end
                else
                begin
                    case (rx_sel)
                        3'h1:
                            if (RX_PAYLOAD_AVAIL_IRQ)
                                state_d = ST_PKT;
                        3'h2:
                            if (RX_PAYLOAD_AVAIL_IRQ)
                                state_d = ST_LOWPWR;
                        3'h3:
                            if (CRC_GOOD_IRQ)
                                state_d = ST_PKT;
                        3'h4:
                            if (LEVEL_IRQ)
                                state_d = ST_OFF;
                        3'h5:
                            if (SYNC_MATCH_IRQ)
                                state_d = ST_OFF;
                        3'h6:
                            if (PREAMBLE_FOUND_IRQ)
                                state_d = ST_OFF;
                        default: state_d = ST_RX;
                    endcase
                end
            ST_PKT:
                case (pkt_sel)
                    3'h0: state_d = ST_OFF;
                    3'h1:
                        if (FIFO_DRAINED_IRQ)
                            state_d = ST_TX;
                    3'h2: state_d = ST_LOWPWR;
                    3'h3: state_d = FREQ_CHANGED ? ST_SYNTH : ST_RX;
                    3'h4: state_d = ST_RX;
                    default: state_d = ST_PKT;
                endcase
            ST_SYNTH:
                state_d = ST_RX;
            ST_LOWPWR:
                state_d = low_power_choice ? ST_IDLE : ST_OFF;
            default: state_d = ST_OFF;
        endcase
        if (stop)
        begin
            state_d = ST_OFF;
            relaunch_d = 1'b0;
        end
    end

    // chip mode seen in the next state
    always @*
    begin
        case (state_d)
            ST_IDLE: mode_d = idle_pwr ? `TLS_MODE_SLEEP
                : `TLS_MODE_STDBY;
            ST_TX: mode_d = `TLS_MODE_TX;
            ST_RX: mode_d = `TLS_MODE_RX;
            ST_PKT: mode_d = `TLS_MODE_RX;
            ST_SYNTH: mode_d = `TLS_MODE_SYNTH;
            ST_TXWAIT: mode_d = CHIP_MODE;
            // at launch the capture is not in yet, so keep the live mode
            default: mode_d = (state_q == ST_OFF) ? CHIP_MODE
                : init_sleep_q ? `TLS_MODE_SLEEP
                : `TLS_MODE_STDBY;
        endcase
    end

    always @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_q <= ST_OFF;
            init_sleep_q <= 1'b0;
            CHIP_MODE <= `TLS_MODE_SLEEP;
            RECEIVER_RELAUNCH <= 1'b0;
            SEQ_STATE <= ST_OFF;
        end
        else
        begin
            // initial mode captured at launch
            if (state_q == ST_OFF && launch && !stop)
                init_sleep_q <= (CHIP_MODE == `TLS_MODE_SLEEP);
            state_q <= state_d;
            SEQ_STATE <= state_d;
            RECEIVER_RELAUNCH <= relaunch_d;
            if (state_q == ST_OFF && state_d == ST_OFF)
            begin
                if (WR && widx == `TLS_REG_STAT)
                    CHIP_MODE <= WDATA[0] ? `TLS_MODE_SLEEP
                        : `TLS_MODE_STDBY;
            end
            else if (state_q == ST_OFF && launch)
                CHIP_MODE <= (state_d == ST_TXWAIT) ? CHIP_MODE : mode_d;
            else
                CHIP_MODE <= mode_d;
        end
    end
endmodule // tls_seq

// ===== tls_seq_monitor.sv
// Purpose: port-level checks for the mode sequencer
// Assumes: one clock, sync active-high reset
// Notes: bound from the bench file
`timescale 1ns/1ps
module tls_seq_monitor
(
    input wire REF_CLK,
    input wire SRST,
    input wire [5:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire TX_COMPLETE_IRQ,
    input wire LEVEL_WAIT_TIMEOUT,
    input wire PREAMBLE_WAIT_TIMEOUT,
    input wire SYNC_WAIT_TIMEOUT,
    input wire [2:0] CHIP_MODE,
    input wire RECEIVER_RELAUNCH,
    input wire [2:0] SEQ_STATE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);
    sequence stop_wr;
        WR && ADDR[5:2] == 4'h0 && WDATA[1];
    endsequence
    sequence to_ev;
        LEVEL_WAIT_TIMEOUT || PREAMBLE_WAIT_TIMEOUT || SYNC_WAIT_TIMEOUT;
    endsequence
    stop_halt_a: assert property (stop_wr |=> SEQ_STATE == 3'h0)
        else $error("stop did not halt");
    idle_mode_a: assert property (SEQ_STATE == 3'h1 |-> CHIP_MODE <= 3'h1)
        else $error("idle not low power");
    tx_mode_a: assert property (SEQ_STATE == 3'h2 |-> CHIP_MODE == 3'h3)
        else $error("tx state without tx mode");
    rx_mode_a: assert property (SEQ_STATE == 3'h3 |-> CHIP_MODE == 3'h5)
        else $error("rx state without rx mode");
    lowpwr_pass_a: assert property (SEQ_STATE == 3'h5 |=> SEQ_STATE <= 3'h1)
        else $error("low power selection did not resolve");
    relaunch_rx_a: assert property (RECEIVER_RELAUNCH |->
        SEQ_STATE == 3'h3 ##1 !RECEIVER_RELAUNCH)
        else $error("relaunch outside rx or too long");
    timeout_exit_a: assert property ((SEQ_STATE == 3'h3 && !WR) ##0 to_ev
        |=> SEQ_STATE != 3'h3 || RECEIVER_RELAUNCH)
        else $error("timeout ignored in rx");
    idle_hold_a: assert property ((SEQ_STATE == 3'h1 && !WR) ##0 to_ev
        |=> SEQ_STATE inside {3'h1, 3'h2, 3'h3})
        else $error("idle left on a foreign event");
    tx_done_a: assert property (SEQ_STATE == 3'h2 && TX_COMPLETE_IRQ && !WR
        |=> SEQ_STATE == 3'h3 || SEQ_STATE == 3'h5)
        else $error("tx completion ignored");
    halt_mode_a: assert property (SEQ_STATE == 3'h0 &&
        $past(SEQ_STATE) == 3'h5 |-> CHIP_MODE <= 3'h1)
        else $error("halt not in low power mode");
endmodule // tls_seq_monitor

// ===== top_level_mode_sequencer_bench.sv
// Purpose: directed bench for the mode sequencer
// Assumes: events are one-cycle pulses
// Notes: ev bits map to the event inputs
`timescale 1ns/1ps
module top_level_mode_sequencer_bench;
    reg REF_CLK = 0, SRST = 1, WR = 0, RD = 0, FREQ_CHANGED = 0;
    reg [5:0] ADDR = 0;
    reg [31:0] WDATA = 0;
    reg [10:0] ev = 0;
    wire [31:0] RDATA;
    wire [2:0] CHIP_MODE;
    wire [2:0] SEQ_STATE;
    wire RECEIVER_RELAUNCH;
    integer fails = 0, check_count = 0, k;
    tls_seq uut (.REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .TX_COMPLETE_IRQ(ev[0]),
        .RX_PAYLOAD_AVAIL_IRQ(ev[1]), .CRC_GOOD_IRQ(ev[2]), .LEVEL_IRQ(ev[3]),
        .SYNC_MATCH_IRQ(ev[4]), .PREAMBLE_FOUND_IRQ(ev[5]),
        .LEVEL_WAIT_TIMEOUT(ev[6]), .PREAMBLE_WAIT_TIMEOUT(ev[7]),
        .SYNC_WAIT_TIMEOUT(ev[8]), .FIFO_LEVEL_IRQ(ev[9]),
        .FIFO_DRAINED_IRQ(ev[10]), .FREQ_CHANGED(FREQ_CHANGED),
        .CHIP_MODE(CHIP_MODE), .RECEIVER_RELAUNCH(RECEIVER_RELAUNCH),
        .SEQ_STATE(SEQ_STATE));
    initial
    begin
        forever #10 REF_CLK = ~REF_CLK;
    end
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge REF_CLK);
        WR <= 1'b1; ADDR <= {a, 2'b00}; WDATA <= d;
        @(posedge REF_CLK);
        WR <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, input [31:0] exp);
    begin
        @(posedge REF_CLK);
        RD <= 1'b1; ADDR <= {a, 2'b00};
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    end
    endtask
    task pulse(input [10:0] b);
    begin
        @(posedge REF_CLK);
        ev <= b;
        @(posedge REF_CLK);
        ev <= 11'h000;
        #1;
    end
    endtask
    // wait a bounded time for a state, mode 7 means do not care
    task st(input [2:0] s, input [2:0] m, input integer n);
    begin
        #1;
        while (SEQ_STATE !== s && n > 0)
        begin
            @(posedge REF_CLK);
            #1 n = n - 1;
        end
        chk(SEQ_STATE, s);
        if (m != 3'h7) chk(CHIP_MODE, m);
    end
    endtask
    function [15:0] cf(input [1:0] s, input lp, input [2:0] rx,
        input [1:0] to, input [2:0] pk);
        cf = (s << 1) | (lp << 3) | (rx << 6) | (to << 9) | (pk << 11);
    endfunction
    // stop, pick the initial mode, configure, launch
    task go(input [15:0] c, input sl);
    begin
        wr(4'h0, 32'h2);
        wr(4'h3, {31'h0, sl});
        wr(4'h1, {16'h0, c});
        wr(4'h0, 32'h1);
    end
    endtask
    task t_regs;
    begin
        rd(4'h1, 32'h0);
        rd(4'h2, 32'h0);
        wr(4'h1, 32'hffffa5c3);
        wr(4'h2, 32'hffffffff);
        wr(4'hf, 32'h1234);
        rd(4'h1, 32'ha5c3);
        rd(4'h2, 32'hfffff);
        rd(4'hf, 32'h0);
        wr(4'h2, 32'h0);
        $display("test regs done");
    end
    endtask
    task t_idle_halt;
    begin
        for (k = 0; k < 2; k = k + 1)
        begin
            go(cf(2'h0, 1'b1, 3'h0, 2'h0, 3'h0) | k, 1'b1);
            st(3'h1, k ? 3'h0 : 3'h1, 8);
            pulse(11'h040);
            chk(SEQ_STATE, 3'h1);
            wr(4'h0, 32'h2);
            st(3'h0, 3'h7, 2);
            go(cf(2'h0, 1'b0, 3'h0, 2'h0, 3'h0), k[0]);
            repeat (3) @(posedge REF_CLK);
            rd(4'h3, {25'h0, k[0], 3'(k ? 0 : 1), 3'h0});
        end
        $display("test idle and halt done");
    end
    endtask
    task t_tx;
    begin
        go(cf(2'h3, 1'b0, 3'h0, 2'h0, 3'h0) | 16'h20, 1'b1);
        st(3'h6, 3'h7, 4);
        pulse(11'h200);
        st(3'h2, 3'h3, 4);
        pulse(11'h001);
        st(3'h3, 3'h5, 4);
        go(cf(2'h2, 1'b0, 3'h0, 2'h0, 3'h0), 1'b0);
        st(3'h2, 3'h3, 4);
        pulse(11'h001);
        st(3'h0, 3'h1, 4);
        $display("test tx done");
    end
    endtask
    task t_timeout;
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            go(cf(2'h1, 1'b0, 3'h0, k[1:0], 3'h0), 1'b1);
            st(3'h3, 3'h5, 4);
            pulse(11'h040 << (k % 3));
            chk(RECEIVER_RELAUNCH, k == 0);
            st(3'((k == 1) ? 2 : (k ? 0 : 3)), 3'h7, 4);
        end
        go(cf(2'h1, 1'b0, 3'h3, 2'h1, 3'h0) | 16'h4000, 1'b1);
        st(3'h3, 3'h5, 4);
        pulse(11'h002);
        st(3'h2, 3'h3, 4);
        $display("test timeout done");
    end
    endtask
    task t_rxsel;
        reg [10:0] b;
        reg [23:0] tbl;
    begin
        tbl = {3'h3, 3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h4, 3'h3};
        for (k = 0; k < 8; k = k + 1)
        begin
            case (k)
                3: b = 11'h006;
                4: b = 11'h008;
                5: b = 11'h010;
                6: b = 11'h020;
                default: b = 11'h002;
            endcase
            go(cf(2'h1, 1'b0, k[2:0], 2'h0, 3'h5), 1'b1);
            st(3'h3, 3'h5, 4);
            pulse(b);
            repeat (2) @(posedge REF_CLK);
            #1 chk(SEQ_STATE, tbl[k * 3 +: 3]);
        end
        $display("test rx select done");
    end
    endtask
    task t_pkt;
        reg [14:0] tbl;
    begin
        tbl = {3'h3, 3'h3, 3'h0, 3'h2, 3'h0};
        for (k = 0; k < 5; k = k + 1)
        begin
            FREQ_CHANGED <= (k == 3);
            go(cf(2'h1, 1'b0, 3'h1, 2'h0, k[2:0]), 1'b1);
            st(3'h3, 3'h5, 4);
            pulse(11'h002);
            if (k == 1) pulse(11'h400);
            if (k == 3)
            begin
                @(posedge REF_CLK);
                #1 chk(CHIP_MODE, 3'h2);
            end
            repeat (3) @(posedge REF_CLK);
            #1 chk(SEQ_STATE, tbl[k * 3 +: 3]);
        end
        $display("test packet done");
    end
    endtask
    task t_timers;
    begin
        wr(4'h2, 32'h1405);
        go(cf(2'h0, 1'b1, 3'h0, 2'h0, 3'h0) | 16'h10, 1'b1);
        st(3'h1, 3'h1, 8);
        st(3'h3, 3'h5, 7000);
        st(3'h1, 3'h1, 7000);
        st(3'h3, 3'h5, 7000);
        wr(4'h0, 32'h2);
        $display("test timers done");
    end
    endtask
    task final_report;
    begin
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    initial
    begin
        #(60000 * 20);
        fails = fails + 1;
        final_report;
    end
    initial
    begin
        repeat (3) @(posedge REF_CLK);
        SRST <= 1'b0;
        t_regs;
        t_idle_halt;
        t_tx;
        t_timeout;
        t_rxsel;
        t_pkt;
        t_timers;
        final_report;
    end
endmodule // top_level_mode_sequencer_bench
bind tls_seq tls_seq_monitor mon (.REF_CLK(REF_CLK), .SRST(SRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .TX_COMPLETE_IRQ(TX_COMPLETE_IRQ),
    .LEVEL_WAIT_TIMEOUT(LEVEL_WAIT_TIMEOUT),
    .PREAMBLE_WAIT_TIMEOUT(PREAMBLE_WAIT_TIMEOUT),
    .SYNC_WAIT_TIMEOUT(SYNC_WAIT_TIMEOUT), .CHIP_MODE(CHIP_MODE),
    .RECEIVER_RELAUNCH(RECEIVER_RELAUNCH), .SEQ_STATE(SEQ_STATE));
